/* hw/ipfcpm_modulator.sv */
// two-phase interleaved pulse modulator with apb register file
//
// Behaviour
// - period divides time base by coded divisor
// - trailing edge: pulse starts each period
// - minimum on-time 40 to 320 ns
// - first dead time before sync turns on
// - second dead time before main turns on
// - on-time capped by period minus dead times
// - minimum off and on times bound duty
// - separate limit threshold per sense channel
// - threshold 1.0 to 1.5 V codes
// - trip counts after selectable debounce time
// - comparator ignored during selectable blanking
// - trip ends pulse; sixteen cycles raise fault
// - dither varies period with line voltage
// - period sweeps 87.5 to 112.5 percent
// - input and output current routing selects
// - seven doubling sense resistance scalings
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ipfcpm_modulator (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ipfcpm_pkg::APB_AW-1:0] i_paddr,
  input wire logic [ipfcpm_pkg::APB_DW-1:0] i_pwdata,
  output logic [ipfcpm_pkg::APB_DW-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_trip_a,
  input wire logic i_trip_b,
  input wire logic [ipfcpm_pkg::ADC_W-1:0] i_line_volt,
  input wire logic [ipfcpm_pkg::ADC_W-1:0] i_sense_channel_a,
  input wire logic [ipfcpm_pkg::ADC_W-1:0] i_sense_channel_b,
  output logic o_main_a,
  output logic o_sync_a,
  output logic o_main_b,
  output logic o_sync_b,
  output logic [ipfcpm_pkg::THR_W-1:0] o_limit_threshold_a,
  output logic [ipfcpm_pkg::THR_W-1:0] o_limit_threshold_b,
  output logic o_input_peak_overcurrent_fault,
  output logic o_irq
);
  import ipfcpm_pkg::*;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // ticks for a 3-bit step code: (code + 1) steps of unit ticks
  function automatic logic [PER_W-1:0] t_steps(input logic [2:0] code,
                                               input logic [PER_W-1:0] unit);
    t_steps = (PER_W'(code) + PER_W'(1)) * unit;
  endfunction

  // sense reading scaled by the selected equivalent resistance
  function automatic logic [CUR_W-1:0] scale_cur(
      input logic [ADC_W:0] v, input logic [2:0] k);
    logic [2:0] kk;
    kk = (k > 3'h6) ? 3'h6 : k; // code 7 behaves as the largest
    scale_cur = (CUR_W'(v) << 6) >> kk;
  endfunction

  // on-time clamp: zero means no pulse, else within min and max
  function automatic logic [PER_W-1:0] on_clamp(
      input logic [PER_W-1:0] duty, input logic [PER_W-1:0] per,
      input logic [PER_W-1:0] mn_on, input logic [PER_W-1:0] mn_off,
      input logic [PER_W-1:0] d1, input logic [PER_W-1:0] d2);
    logic [PER_W-1:0] mx;
    mx = per - d1 - d2;
    if (per - mn_off < mx) begin
      mx = per - mn_off;
    end
    if (duty == '0 || mx < mn_on) begin
      on_clamp = '0;
    end else if (duty > mx) begin
      on_clamp = mx;
    end else if (duty < mn_on) begin
      on_clamp = mn_on;
    end else begin
      on_clamp = duty;
    end
  endfunction

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic en_q, dith_q, inr_q, outr_q; // control bits
  logic [2:0] freq_q; // switching_frequency_setting
  logic [2:0] minon_c_q, minoff_c_q, td1_c_q, td2_c_q; // step codes
  logic [1:0] deb_c_q, blank_c_q; // limit filter codes
  logic [PER_W-1:0] duty_q [2]; // requested on-time in ticks
  logic [THR_W-1:0] thr_q [2]; // limit threshold codes
  logic [2:0] scl_q [2]; // equivalent resistance codes
  logic [ST_W-1:0] status_q, mask_q; // sticky events and mask
  logic [CUR_W-1:0] iin_q, iout_q; // routed current readings
  logic pready_q, pslverr_q, irq_q, fault_q; // output flops
  logic [APB_DW-1:0] prdata_q; // read data flop
  logic [1:0] div_q; // time base divider
  logic tick_q; // one-cycle tick at the time base rate
  logic [PER_W-1:0] cnt_q [2], per_q [2], on_q [2]; // phase timing
  logic [1:0] run_q, main_q, sync_q; // phase run and drive flops
  logic [1:0] s1_q, s2_q, s3_q, tl_q; // trip synchronisers
  logic [PER_W-1:0] blank_q [2]; // blanking down counters
  logic [2:0] deb_q [2]; // debounce up counters
  logic [1:0] term_q; // pulse terminated this period
  logic [3:0] lim_q [2]; // consecutive limited cycles

  // ----------------------------------------------------------------
  // decoded settings
  // ----------------------------------------------------------------
  logic [PER_W-1:0] minon_t, minoff_t, td1_t, td2_t, deb_t, blank_t;
  logic [PER_W-1:0] nom_per, next_per; // nominal and next period
  logic [23:0] prod; // line voltage times quarter of nominal period
  logic [1:0] cyc_end, main_nx, qual, fault_evt; // per phase events
  logic wr_en; // write taken at this edge
  logic [ST_W-1:0] st_set; // hardware status events

  assign minon_t = t_steps(minon_c_q, PER_W'(STEP_TICKS));
  assign minoff_t = t_steps(minoff_c_q, PER_W'(STEP_TICKS));
  assign td1_t = t_steps(td1_c_q, PER_W'(STEP_TICKS));
  assign td2_t = t_steps(td2_c_q, PER_W'(STEP_TICKS));
  assign deb_t = t_steps({1'b0, deb_c_q}, PER_W'(DEB_TICKS));
  assign blank_t = t_steps({1'b0, blank_c_q}, PER_W'(BLANK_TICKS));
  assign nom_per = DIV_TAB[freq_q];
  // quarter period times line keeps the top of the sweep at 112.5 percent
  assign prod = 24'(nom_per >> 2) * 24'(i_line_volt);
  // dither: 7/8 of nominal plus up to 1/4 scaled by line voltage
  assign next_per = dith_q ?
      nom_per - (nom_per >> 3) + PER_W'(prod >> 12) : nom_per;

  // ----------------------------------------------------------------
  // time base divider
  // ----------------------------------------------------------------
  // tick pulses once every TB_DIV system cycles
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= 2'h0;
      tick_q <= 1'b0;
    end else begin
      div_q <= (div_q == 2'(TB_DIV - 1)) ? 2'h0 : div_q + 2'h1;
      tick_q <= (div_q == 2'(TB_DIV - 1));
    end
  end

  // ----------------------------------------------------------------
  // apb slave and register file
  // ----------------------------------------------------------------
  assign wr_en = i_psel && i_penable && i_pwrite && pready_q;

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= i_psel && i_penable && !pready_q;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      if (i_psel && i_penable && !pready_q) begin
        unique case (i_paddr)
          ADDR_CTRL: prdata_q <= APB_DW'({outr_q, inr_q, freq_q,
                                          dith_q, en_q});
          ADDR_TIMING: prdata_q <= APB_DW'({blank_c_q, deb_c_q,
              td2_c_q, td1_c_q, minoff_c_q, minon_c_q});
          ADDR_DUTY_A: prdata_q <= APB_DW'(duty_q[0]);
          ADDR_DUTY_B: prdata_q <= APB_DW'(duty_q[1]);
          ADDR_THRESH: prdata_q <= APB_DW'({thr_q[1], 2'h0, thr_q[0]});
          ADDR_SCALE: prdata_q <= APB_DW'({scl_q[1], 1'b0, scl_q[0]});
          ADDR_STATUS: prdata_q <= APB_DW'(status_q);
          ADDR_MASK: prdata_q <= APB_DW'(mask_q);
          ADDR_IIN: prdata_q <= APB_DW'(iin_q);
          ADDR_IOUT: prdata_q <= APB_DW'(iout_q);
          ADDR_PERIOD: prdata_q <= APB_DW'(per_q[0]);
          default: pslverr_q <= 1'b1; // unmapped address
        endcase
      end
    end
  end

  // writable settings, taken at the completing access edge
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {en_q, dith_q, inr_q, outr_q} <= 4'h0;
      freq_q <= RST_CODE;
      {minon_c_q, minoff_c_q, td1_c_q, td2_c_q} <= {4{RST_CODE}};
      {deb_c_q, blank_c_q} <= 4'h0;
      duty_q <= '{RST_DUTY, RST_DUTY};
      thr_q <= '{RST_THR, RST_THR};
      scl_q <= '{RST_CODE, RST_CODE};
      mask_q <= RST_MASK;
    end else if (wr_en) begin
      unique case (i_paddr)
        ADDR_CTRL: begin
          en_q <= i_pwdata[CTRL_EN];
          dith_q <= i_pwdata[CTRL_DITH];
          freq_q <= i_pwdata[CTRL_FREQ +: 3];
          inr_q <= i_pwdata[CTRL_INR];
          outr_q <= i_pwdata[CTRL_OUTR];
        end
        ADDR_TIMING: begin
          minon_c_q <= i_pwdata[TIM_MINON +: 3];
          minoff_c_q <= i_pwdata[TIM_MINOFF +: 3];
          td1_c_q <= i_pwdata[TIM_TD1 +: 3];
          td2_c_q <= i_pwdata[TIM_TD2 +: 3];
          deb_c_q <= i_pwdata[TIM_DEB +: 2];
          blank_c_q <= i_pwdata[TIM_BLANK +: 2];
        end
        ADDR_DUTY_A: duty_q[0] <= i_pwdata[PER_W-1:0];
        ADDR_DUTY_B: duty_q[1] <= i_pwdata[PER_W-1:0];
        ADDR_THRESH: begin
          thr_q[0] <= i_pwdata[THR_W-1:0];
          thr_q[1] <= i_pwdata[THR_B +: THR_W];
        end
        ADDR_SCALE: begin
          scl_q[0] <= i_pwdata[2:0];
          scl_q[1] <= i_pwdata[SCL_B +: 3];
        end
        ADDR_MASK: mask_q <= i_pwdata[ST_W-1:0];
        default: ; // status clears below; other offsets are read-only or unmapped
      endcase
    end
  end

  // sticky status: hardware set wins over a write-one clear
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~((wr_en && i_paddr == ADDR_STATUS) ?
                   i_pwdata[ST_W-1:0] : '0)) | st_set;
    end
  end

  // interrupt and fault level outputs
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
      fault_q <= |status_q[ST_FAULT_A +: 2];
    end
  end

  // ----------------------------------------------------------------
  // current routing and scaling
  // ----------------------------------------------------------------
  // input current from both channels or a alone, output from b or a
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      iin_q <= '0;
      iout_q <= '0;
    end else begin
      iin_q <= inr_q ? scale_cur({1'b0, i_sense_channel_a}, scl_q[0]) :
               scale_cur({1'b0, i_sense_channel_a}, scl_q[0]) +
               scale_cur({1'b0, i_sense_channel_b}, scl_q[1]);
      iout_q <= outr_q ? scale_cur({1'b0, i_sense_channel_a}, scl_q[0]) :
                scale_cur({1'b0, i_sense_channel_b}, scl_q[1]);
    end
  end

  // ----------------------------------------------------------------
  // phase timing and drive
  // ----------------------------------------------------------------
  always_comb begin
    st_set = '0;
    for (int c = 0; c < 2; c++) begin
      cyc_end[c] = tick_q && run_q[c] && (cnt_q[c] == per_q[c] - 1'b1);
      qual[c] = tl_q[c] && main_q[c] && (blank_q[c] == '0) &&
                (PER_W'(deb_q[c]) >= deb_t);
      main_nx[c] = en_q && run_q[c] && (cnt_q[c] < on_q[c]) &&
                   !term_q[c] && !qual[c];
      fault_evt[c] = cyc_end[c] && term_q[c] &&
                     (lim_q[c] == 4'(LIM_CYCLES - 1));
      st_set[ST_FAULT_A + c] = fault_evt[c];
      st_set[ST_LIMIT_A + c] = qual[c];
    end
  end

  // period counters; phase b starts half a period after phase a
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '{12'h000, 12'h000};
      per_q <= '{DIV_TAB[0], DIV_TAB[0]};
      on_q <= '{12'h000, 12'h000};
      run_q <= 2'h0;
    end else if (!en_q) begin
      cnt_q <= '{12'h000, 12'h000};
      run_q <= 2'h0;
    end else begin
      run_q[0] <= 1'b1;
      if (tick_q && run_q[0] && cnt_q[0] == (per_q[0] >> 1)) begin
        run_q[1] <= 1'b1; // interleave offset
      end
      for (int c = 0; c < 2; c++) begin
        if (cyc_end[c]) begin
          cnt_q[c] <= '0;
          per_q[c] <= next_per;
          on_q[c] <= on_clamp(duty_q[c], next_per, minon_t, minoff_t,
                              td1_t, td2_t);
        end else if (tick_q && run_q[c]) begin
          cnt_q[c] <= cnt_q[c] + 1'b1;
        end
      end
    end
  end

  // main rises at period start, falls at on-time; sync fills the gap
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      main_q <= 2'h0;
      sync_q <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        main_q[c] <= main_nx[c];
        sync_q[c] <= en_q && run_q[c] && !term_q[c] && !qual[c] &&
                     (cnt_q[c] >= on_q[c] + td1_t) &&
                     (cnt_q[c] < per_q[c] - td2_t) &&
                     (per_q[c] - td2_t >= on_q[c] + td1_t + minon_t);
      end
    end
  end

  // ----------------------------------------------------------------
  // cycle-by-cycle current limit
  // ----------------------------------------------------------------
  // comparator pins: three flops, change taken when last two agree
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {s1_q, s2_q, s3_q, tl_q} <= 8'h00;
    end else begin
      s1_q <= {i_trip_b, i_trip_a};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int c = 0; c < 2; c++) begin
        if (s2_q[c] == s3_q[c]) begin
          tl_q[c] <= s3_q[c];
        end
      end
    end
  end

  // blanking from each main rising edge, then debounce the trip
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blank_q <= '{12'h000, 12'h000};
      deb_q <= '{3'h0, 3'h0};
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (main_nx[c] && !main_q[c]) begin
          blank_q[c] <= blank_t;
        end else if (tick_q && blank_q[c] != '0) begin
          blank_q[c] <= blank_q[c] - 1'b1;
        end
        if (tl_q[c] && main_q[c] && blank_q[c] == '0) begin
          if (tick_q && PER_W'(deb_q[c]) < deb_t) begin
            deb_q[c] <= deb_q[c] + 3'h1;
          end
        end else begin
          deb_q[c] <= 3'h0;
        end
      end
    end
  end

  // termination for the rest of the period, consecutive count
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      term_q <= 2'h0;
      lim_q <= '{4'h0, 4'h0};
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (qual[c]) begin
          term_q[c] <= 1'b1;
        end else if (cyc_end[c] || !en_q) begin
          term_q[c] <= 1'b0;
        end
        if (!en_q || (cyc_end[c] && (!term_q[c] || fault_evt[c]))) begin
          lim_q[c] <= 4'h0;
        end else if (cyc_end[c]) begin
          lim_q[c] <= lim_q[c] + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_main_a = main_q[0];
  assign o_sync_a = sync_q[0];
  assign o_main_b = main_q[1];
  assign o_sync_b = sync_q[1];
  assign o_limit_threshold_a = thr_q[0];
  assign o_limit_threshold_b = thr_q[1];
  assign o_input_peak_overcurrent_fault = fault_q;
  assign o_irq = irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_limited_end;
    cyc_end[0] && term_q[0] && lim_q[0] == 4'hf;
  endsequence

  chk_period_load: assert property (
    (cyc_end[0] && !dith_q) |=> per_q[0] == DIV_TAB[$past(freq_q)]
  ) else $error("period not loaded from divisor table");
  chk_trail_edge: assert property (
    $rose(main_q[0]) |-> $past(cnt_q[0]) == '0
  ) else $error("main pulse did not start at period start");
  chk_on_floor: assert property (
    $changed(on_q[0]) |-> on_q[0] == '0 || on_q[0] >= $past(minon_t)
  ) else $error("on-time below minimum");
  chk_dead_one: assert property (
    $rose(sync_q[0]) |-> !main_q[0] && !$past(main_q[0], 2)
  ) else $error("sync rose too soon after main");
  chk_dead_two: assert property (
    $rose(main_q[0]) |-> !sync_q[0] && !$past(sync_q[0], 2)
  ) else $error("main rose too soon after sync");
  chk_on_cap: assert property (
    cyc_end[0] |=> on_q[0] + $past(td1_t) + $past(td2_t) <= per_q[0]
  ) else $error("on-time exceeds period less dead times");
  chk_dith_span: assert property (
    (cyc_end[0] && dith_q) |=>
      per_q[0] >= $past(nom_per) - ($past(nom_per) >> 3) &&
      per_q[0] <= $past(nom_per) + ($past(nom_per) >> 3)
  ) else $error("dithered period out of range");
  chk_blank_hold: assert property (
    $rose(term_q[0]) |-> $past(blank_q[0]) == '0
  ) else $error("trip accepted during blanking");
  chk_trip_stops: assert property (
    qual[0] |=> !main_q[0] ##1 !main_q[0]
  ) else $error("limited pulse not terminated");
  chk_fault_sixteen: assert property (
    s_limited_end |=> status_q[ST_FAULT_A] ##1 o_input_peak_overcurrent_fault
  ) else $error("fault not raised after sixteen cycles");
  chk_clean_reset: assert property (
    (cyc_end[0] && !term_q[0] && en_q) |=> lim_q[0] == 4'h0
  ) else $error("limit count not cleared by clean cycle");
endmodule
`default_nettype wire

/* hw/ipfcpm_pkg.sv */
// constants and register map of the interleaved pfc pulse modulator
package ipfcpm_pkg;
  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000; // system clock rate
  localparam int TB_HZ = 25_000_000; // modulator time base rate
  localparam int TB_DIV = CLK_HZ / TB_HZ; // system cycles per tick
  localparam int TICK_NS = 1_000_000_000 / TB_HZ; // one tick in ns
  localparam int STEP_NS = 40; // on-time and dead time step
  localparam int STEP_TICKS = (STEP_NS + TICK_NS - 1) / TICK_NS;
  localparam int DEB_NS = 40; // debounce step
  localparam int DEB_TICKS = (DEB_NS + TICK_NS - 1) / TICK_NS;
  localparam int BLANK_NS = 480; // blanking step
  localparam int BLANK_TICKS = (BLANK_NS + TICK_NS - 1) / TICK_NS;
  localparam int LIM_CYCLES = 16; // limited cycles before fault
  // ----------------------------------------------------------------
  // widths and period table
  // ----------------------------------------------------------------
  localparam int PER_W = 12; // period counter width
  localparam int ADC_W = 12; // sense and line sample width
  localparam int CUR_W = 20; // scaled current width
  localparam int APB_AW = 8; // apb address width
  localparam int APB_DW = 32; // apb data width
  localparam int THR_W = 6; // limit threshold code width
  localparam int ST_W = 4; // status and mask width
  // divisors of the time base for frequency codes 0..7
  localparam logic [PER_W-1:0] DIV_TAB [8] = '{
    12'h4e2, 12'h340, 12'h22c, 12'h180,
    12'h116, 12'h0d0, 12'h09c, 12'h080};
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_TIMING = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_DUTY_A = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_DUTY_B = 8'h0c;
  localparam logic [APB_AW-1:0] ADDR_THRESH = 8'h10;
  localparam logic [APB_AW-1:0] ADDR_SCALE = 8'h14;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h18;
  localparam logic [APB_AW-1:0] ADDR_MASK = 8'h1c;
  localparam logic [APB_AW-1:0] ADDR_IIN = 8'h20;
  localparam logic [APB_AW-1:0] ADDR_IOUT = 8'h24;
  localparam logic [APB_AW-1:0] ADDR_PERIOD = 8'h28;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN = 0; // modulator enable
  localparam int CTRL_DITH = 1; // dither enable
  localparam int CTRL_FREQ = 2; // switching_frequency_setting lsb
  localparam int CTRL_INR = 5; // input_current_route_sel
  localparam int CTRL_OUTR = 6; // output_current_route_sel
  localparam int TIM_MINON = 0; // minimum on-time code lsb
  localparam int TIM_MINOFF = 3; // minimum off-time code lsb
  localparam int TIM_TD1 = 6; // main_to_sync_deadtime lsb
  localparam int TIM_TD2 = 9; // sync_to_main_deadtime lsb
  localparam int TIM_DEB = 12; // debounce code lsb
  localparam int TIM_BLANK = 14; // blanking code lsb
  localparam int THR_B = 8; // limit_threshold_b lsb
  localparam int SCL_B = 4; // channel b scale code lsb
  localparam int ST_FAULT_A = 0; // fault status bits
  localparam int ST_LIMIT_A = 2; // limit event status bits
  localparam logic [2:0] RST_CODE = 3'h0; // code fields
  localparam logic [PER_W-1:0] RST_DUTY = 12'h000;
  localparam logic [THR_W-1:0] RST_THR = 6'h3f;
  localparam logic [ST_W-1:0] RST_MASK = 4'h0;
endpackage

/* testbench/ipfcpm_comparator_model.sv */
// comparator model: trips a fixed time after the gate rises
`timescale 1ns/1ps
`default_nettype none
module ipfcpm_comparator_model (
  input wire logic i_clk_sys,
  input wire logic i_main,
  input wire logic i_arm,
  output logic o_trip
);
  logic [7:0] cnt_q; // clocks since gate rise
  // ramp current: trips after the blanking span, clears with the gate
  always_ff @(posedge i_clk_sys) begin
    cnt_q <= i_main ? cnt_q + 8'h01 : 8'h00;
    o_trip <= i_arm && i_main && (cnt_q > 8'd40);
  end
endmodule
`default_nettype wire

/* testbench/interleaved_pfc_pwm_modulator_test.sv */
// self-checking bench of the pulse modulator
`timescale 1ns/1ps
`default_nettype none
module interleaved_pfc_pwm_modulator_test;
  import ipfcpm_pkg::*;
  // ---------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic arm = 1'b0, err, pready, pslverr, trip_a, m_a, s_a, m_b, s_b;
  logic fault, irq, trip_b;
  logic [APB_AW-1:0] addr = '0;
  logic [APB_DW-1:0] wd = '0, rd, prdata;
  logic [ADC_W-1:0] line = '0, sa = '0, sb = '0;
  logic [THR_W-1:0] thr_a, thr_b;
  int fail_count = 0, total_checks = 0, w, d;
  int divs [8] = '{1250, 832, 556, 384, 278, 208, 156, 128};
  initial begin
    forever #10 clk = ~clk;
  end
  ipfcpm_modulator ipfcpm_modulator_inst (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
    .i_pwdata(wd), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_trip_a(trip_a), .i_trip_b(trip_b),
    .i_line_volt(line), .i_sense_channel_a(sa), .i_sense_channel_b(sb),
    .o_main_a(m_a), .o_sync_a(s_a), .o_main_b(m_b), .o_sync_b(s_b),
    .o_limit_threshold_a(thr_a), .o_limit_threshold_b(thr_b),
    .o_input_peak_overcurrent_fault(fault), .o_irq(irq));
  ipfcpm_comparator_model ipfcpm_comparator_model_inst (.i_clk_sys(clk),
    .i_main(m_a), .i_arm(arm), .o_trip(trip_a));
  ipfcpm_comparator_model ipfcpm_comparator_model_b_inst (.i_clk_sys(clk),
    .i_main(m_b), .i_arm(arm), .o_trip(trip_b));
  // expected scaled current reading for a sample and scale code
  function automatic logic [31:0] cur(input logic [11:0] v, input int k);
    return (32'(v) << 6) >> ((k > 6) ? 6 : k);
  endfunction
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input int v);
    psel <= 1'b1;
    pwr <= wr;
    addr <= a;
    wd <= v;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // high time of one whole main pulse, in clocks
  task automatic width(output int c);
    c = 0;
    while (m_a === 1'b1) @(posedge clk);
    while (m_a !== 1'b1) @(posedge clk);
    while (m_a === 1'b1) begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic finish_test;
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    w = $urandom(32'h83b18014);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    line <= $urandom;
    sa <= $urandom;
    sb <= $urandom;
    check(thr_a, 6'h3f);
    apb(0, ADDR_THRESH, 0);
    check(rd, 32'h3f3f);
    apb(0, 8'h80, 0);
    check(err, 1'b1);
    w = $urandom & 32'h3f3f;
    apb(1, ADDR_THRESH, w);
    check({thr_b, 2'h0, thr_a}, w);
    apb(1, ADDR_SCALE, 32'h52);
    apb(0, ADDR_IIN, 0);
    check(rd, cur(sa, 2) + cur(sb, 5));
    apb(0, ADDR_IOUT, 0);
    check(rd, cur(sb, 5));
    for (int k = 0; k < 8; k++) begin
      apb(1, ADDR_CTRL, 1 | (k << CTRL_FREQ));
      repeat (5100) @(posedge clk);
      apb(0, ADDR_PERIOD, 0);
      check(rd, divs[k]);
    end
    apb(1, ADDR_CTRL, 3 | (7 << CTRL_FREQ));
    repeat (600) @(posedge clk);
    apb(0, ADDR_PERIOD, 0);
    check(rd >= 112 && rd <= 144, 1);
    apb(1, ADDR_CTRL, 1 | (7 << CTRL_FREQ));
    repeat (600) @(posedge clk);
    d = 5 + $urandom % 100;
    apb(1, ADDR_DUTY_A, d);
    width(w);
    width(w);
    check(w, 2 * d);
    apb(1, ADDR_TIMING, 32'h43);
    apb(1, ADDR_DUTY_A, 200);
    width(w);
    width(w);
    check(w, 250);
    apb(1, ADDR_DUTY_A, 1);
    width(w);
    width(w);
    check(w, 8);
    while (s_a !== 1'b1) @(posedge clk);
    w = 0;
    while (s_a === 1'b1) begin
      @(posedge clk);
      w++;
    end
    check(w, 242);
    apb(1, ADDR_DUTY_A, 60);
    apb(1, ADDR_DUTY_B, 60);
    apb(1, ADDR_MASK, 1);
    arm <= 1'b1;
    width(w);
    width(w);
    check(w < 120, 1);
    repeat (5200) @(posedge clk);
    check({fault, irq}, 2'h3);
    arm <= 1'b0;
    repeat (600) @(posedge clk);
    apb(0, ADDR_STATUS, 0);
    check(rd & 15, 15);
    apb(1, ADDR_STATUS, 15);
    apb(0, ADDR_STATUS, 0);
    check(rd & 15, 0);
    check({fault, irq}, 2'h0);
    finish_test();
  end
endmodule
`default_nettype wire
